/* File: bench/ebid_core_monitor.sv */
// port-level assertions for the decoder core
`timescale 1ns/1ps
`default_nettype none
module ebid_core_monitor
	import ebid_pkg::*;
(
	input wire logic                          ref_clk,
	input wire logic                          nrst,
	input wire logic [INSTR_W-1:0]            progData,
	input wire logic [7:0]                    regRdata,
	input wire logic                          wakeUp,
	input wire logic [PC_W-1:0]               pcOut,
	input wire logic [BANK_W+REG_IDX_W-1:0]   regAddr,
	input wire logic                          regWe,
	input wire logic [7:0]                    regWdata,
	input wire logic [7:0]                    accOut,
	input wire logic [2:0]                    flagsOut,
	input wire logic                          timeoutFlag,
	input wire logic                          powerDownFlag,
	input wire logic                          wdtClear,
	input wire logic                          oscStop,
	input wire logic                          globalIntEn
);
	logic [1:0] opTop;
	logic [3:0] op4;
	logic [6:0] op7;
	logic [9:0] litLong;
	logic [2:0] bitNum;
	logic [7:0] swapped;
	logic [7:0] rrcRes;
	logic [2:0] rrcFlags;
	logic [4:0] pcIncHi;
	// plain nets so that $past only ever sees a signal
	assign opTop    = progData[12:11];
	assign op4      = progData[12:9];
	assign op7      = progData[12:6];
	assign litLong  = progData[9:0];
	assign bitNum   = progData[8:6];
	assign swapped  = {regRdata[3:0], regRdata[7:4]};
	assign rrcRes   = {flagsOut[0], regRdata[7:1]};
	assign rrcFlags = {flagsOut[2:1], regRdata[0]};
	assign pcIncHi  = pcOut[13:9] + {4'h0, &pcOut[8:0]};
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	chk_sleep_flags: assert property ($rose(oscStop) |->
		wdtClear && !powerDownFlag && timeoutFlag) else $error("sleep flags");
	chk_wdt_pulse: assert property (wdtClear |=> !wdtClear)
		else $error("watchdog clear longer than one cycle");
	chk_sleep_hold: assert property (oscStop && $past(oscStop) |->
		$stable(pcOut)) else $error("fetch moved while asleep");
	chk_int_vector: assert property ($changed(pcOut) &&
		$past(progData) == OP_SOFT_INT |-> pcOut == SOFT_INT_VECTOR)
		else $error("soft interrupt target wrong");
	chk_ret_int: assert property ($changed(pcOut) &&
		$past(progData) == OP_RET_INT |-> globalIntEn)
		else $error("interrupts not enabled on return");
	chk_int_off: assert property ($changed(pcOut) &&
		$past(progData) == OP_INT_DIS |-> !globalIntEn)
		else $error("interrupts not disabled");
	chk_wdt_flags: assert property (wdtClear && !oscStop |->
		timeoutFlag && powerDownFlag)
		else $error("watchdog clear flags wrong");
	chk_jump_target: assert property ($changed(pcOut) &&
		$past(opTop) == 2'b10 |-> pcOut[9:0] == $past(litLong))
		else $error("jump target wrong");
	chk_jump_idle: assert property ($changed(pcOut) &&
		$past(opTop) == 2'b10 |=> $stable(pcOut)[*3])
		else $error("jump shorter than two cycles");
	chk_table_page: assert property ($changed(pcOut) &&
		$past(progData) == OP_TABLE |-> pcOut[13:9] == $past(pcIncHi))
		else $error("table jump touched upper counter bits");
	chk_bit_set: assert property (regWe && $past(op4) == 4'b0101 |->
		regWdata == ($past(regRdata) | (8'h01 << $past(bitNum))))
		else $error("bit set result wrong");
	chk_swap_flags: assert property (regWe && $past(op7) == 7'h1D |->
		regWdata == $past(swapped) && $stable(flagsOut))
		else $error("nibble swap wrong");
	chk_rrc_carry: assert property (regWe && $past(op7) == 7'h19 |->
		regWdata == $past(rrcRes) && flagsOut == $past(rrcFlags))
		else $error("rotate right through carry wrong");
endmodule
`default_nettype wire

/* File: bench/ebid_core_tb_top.sv */
// self-checking bench running a small program through the decoder core
`timescale 1ns/1ps
`default_nettype none
module ebid_core_tb_top
	import ebid_pkg::*;
;
	logic               ref_clk;
	logic               nrst;
	logic               wakeUp;
	logic [INSTR_W-1:0] progData;
	logic [PC_W-1:0]    pcOut;
	logic [7:0]         regRdata, regAddr, regWdata, accOut;
	logic [2:0]         flagsOut, fl, b;
	logic               regWe, timeoutFlag, powerDownFlag, c;
	logic               wdtClear, oscStop, globalIntEn;
	logic [19:0]        expQ [$];
	logic [19:0]        e;
	int                 bad_count, n_tests, i;
	logic [13:0]        ap;
	logic [7:0]         k, k2, x, y, z, w, v, r18;
	logic [8:0]         sum;
	logic [4:0]         nib;

	ebid_core dut (
		.ref_clk(ref_clk), .nrst(nrst), .progData(progData),
		.regRdata(regRdata), .wakeUp(wakeUp), .pcOut(pcOut),
		.regAddr(regAddr), .regWe(regWe), .regWdata(regWdata),
		.accOut(accOut), .flagsOut(flagsOut), .timeoutFlag(timeoutFlag),
		.powerDownFlag(powerDownFlag), .wdtClear(wdtClear),
		.oscStop(oscStop), .globalIntEn(globalIntEn)
	);
	ebid_mem_model mem (
		.ref_clk(ref_clk), .pcOut(pcOut), .regAddr(regAddr),
		.regWe(regWe), .regWdata(regWdata), .progData(progData),
		.regRdata(regRdata)
	);

	initial ref_clk = 1'b0;
	always #25 ref_clk = ~ref_clk;

	task automatic emit(input logic [12:0] op);
		mem.prog[ap[7:0]] = op;
		ap = ap + 14'h0001;
	endtask
	// register-operand form: seven opcode bits, then the register index
	task automatic rop(input logic [6:0] p, input logic [5:0] r);
		emit({p, r});
	endtask
	task automatic note(input logic [7:0] a, input logic [7:0] d,
		input logic chk = 1'b0, input logic [2:0] f = 3'h0);
		expQ.push_back({chk, f, a, d});
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			bad_count++;
		end
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// every write strobe is matched to the oldest noted write; an
	// unexpected write meets an unknown note and fails
	always @(negedge ref_clk)
		if (nrst === 1'b1 && regWe === 1'b1)
		begin
			e = (expQ.size() > 0) ? expQ.pop_front() : 20'hXXXXX;
			check({regAddr, regWdata}, e[15:0]);
			if (e[19])
				check({13'h0, flagsOut}, {13'h0, e[18:16]});
		end

	initial
	begin
		nrst = 1'b0;
		wakeUp = 1'b0;
		bad_count = 0;
		n_tests = 0;
		void'($urandom(1010));
		for (i = 0; i < 256; i++)
		begin
			mem.prog[i] = 13'h0000;
			mem.regs[i] = 8'($urandom());
		end
		k = 8'($urandom());
		k2 = 8'($urandom());
		b = 3'($urandom());
		mem.regs[8'h14] = 8'h01;
		mem.regs[8'h16] = 8'hFF;
		mem.regs[8'h17] = mem.regs[8'h17] | 8'h02;
		ap = 14'h0000;
		emit(13'h1420);
		emit(OP_RET_INT);
		mem.prog[8'h80] = {5'b11100, k2};
		ap = 14'h0020;
		emit({5'b11000, k});
		x = mem.regs[8'h10];
		sum = {1'b0, x} + {1'b0, k};
		nib = {1'b0, x[3:0]} + {1'b0, k[3:0]};
		fl = {sum[7:0] == 8'h00, nib[4], sum[8]};
		rop(7'h0F, 6'h10);
		note(8'h10, sum[7:0], 1'b1, fl);
		c = sum[8];
		y = mem.regs[8'h11];
		rop(7'h19, 6'h11);
		note(8'h11, {c, y[7:1]});
		c = y[0];
		z = mem.regs[8'h12];
		rop(7'h1B, 6'h12);
		note(8'h12, {z[6:0], c});
		w = mem.regs[8'h13];
		rop(7'h1D, 6'h13);
		note(8'h13, {w[3:0], w[7:4]});
		rop(7'h17, 6'h14);
		note(8'h14, 8'h00);
		rop(7'h01, 6'h15);
		rop(7'h1F, 6'h16);
		note(8'h16, 8'h00);
		rop(7'h01, 6'h15);
		v = mem.regs[8'h17];
		rop(7'h17, 6'h17);
		note(8'h17, v - 8'h01);
		rop(7'h01, 6'h15);
		note(8'h15, k);
		r18 = mem.regs[8'h18] | (8'h01 << b);
		emit({4'b0101, b, 6'h18});
		note(8'h18, r18);
		r18 = r18 & ~(8'h01 << (b + 3'h1));
		emit({4'b0100, b + 3'h1, 6'h18});
		note(8'h18, r18);
		// clear bit skips, set bit skips, then a test that falls through
		emit({4'b0110, b + 3'h1, 6'h18});
		rop(7'h01, 6'h15);
		emit({4'b0111, b, 6'h18});
		rop(7'h01, 6'h15);
		emit({4'b0111, b + 3'h1, 6'h18});
		rop(7'h01, 6'h19);
		note(8'h19, k);
		emit(13'h1080);
		rop(7'h01, 6'h1A);
		note(8'h1A, k2);
		emit(13'h1802);
		emit(OP_TABLE);
		rop(7'h01, 6'h15);
		rop(7'h01, 6'h15);
		rop(7'h01, 6'h1B);
		note(8'h1B, 8'h02);
		emit(OP_INT_DIS);
		emit(OP_SOFT_INT);
		rop(7'h01, 6'h1C);
		note(8'h1C, 8'h02);
		emit(13'h1840);
		rop(7'h01, 6'h04);
		note(8'h04, 8'h40);
		rop(7'h01, 6'h10);
		note(8'h50, 8'h40);
		emit(OP_WDT_CLEAR);
		emit(OP_SLEEP);
		rop(7'h01, 6'h11);
		note(8'h51, 8'h40);
		emit({3'b101, ap[9:0]});
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		for (i = 0; i < 600 && oscStop !== 1'b1; i++)
			@(posedge ref_clk);
		@(negedge ref_clk);
		check({14'h0, timeoutFlag, powerDownFlag}, 16'h0002);
		check(16'(expQ.size()), 16'h0001);
		$display("program run ended, %0d checks so far", n_tests);
		@(posedge ref_clk);
		wakeUp <= 1'b1;
		for (i = 0; i < 100 && expQ.size() != 0; i++)
			@(posedge ref_clk);
		@(negedge ref_clk);
		check({15'h0, globalIntEn}, 16'h0001);
		check({8'h0, accOut}, 16'h0040);
		check(16'(expQ.size()), 16'h0000);
		$display("sleep and wake ended");
		finish_test();
	end

	// whole run is about a hundred cycles; this leaves wide slack
	initial
	begin
		repeat (3000) @(posedge ref_clk);
		$display("watchdog expired at t=%0t", $time);
		bad_count++;
		finish_test();
	end
endmodule

bind ebid_core ebid_core_monitor chk (
	.ref_clk(ref_clk), .nrst(nrst), .progData(progData),
	.regRdata(regRdata), .wakeUp(wakeUp), .pcOut(pcOut),
	.regAddr(regAddr), .regWe(regWe), .regWdata(regWdata),
	.accOut(accOut), .flagsOut(flagsOut), .timeoutFlag(timeoutFlag),
	.powerDownFlag(powerDownFlag), .wdtClear(wdtClear),
	.oscStop(oscStop), .globalIntEn(globalIntEn)
);
`default_nettype wire

/* File: bench/ebid_mem_model.sv */
// program memory and register file at the core's far side
`timescale 1ns/1ps
`default_nettype none
module ebid_mem_model
	import ebid_pkg::*;
(
	input  wire logic                 ref_clk,
	input  wire logic [PC_W-1:0]      pcOut,
	input  wire logic [7:0]           regAddr,
	input  wire logic                 regWe,
	input  wire logic [7:0]           regWdata,
	output logic      [INSTR_W-1:0]   progData,
	output logic      [7:0]           regRdata
);
	logic [INSTR_W-1:0] prog [0:255];
	logic [7:0]         regs [0:255];
	// zero-wait reads; only the low address byte decodes, so programs
	// must stay inside the first 256 words
	assign progData = prog[pcOut[7:0]];
	assign regRdata = regs[regAddr];
	// a write lands at the edge that ends the one-cycle strobe
	always @(posedge ref_clk)
		if (regWe)
			regs[regAddr] <= regWdata;
endmodule
`default_nettype wire

/* File: hw/ebid_alu.sv */
// combinational eight-bit alu with carry, digit carry and zero
`timescale 1ns/1ps
`default_nettype none
module ebid_alu
	import ebid_pkg::*;
(
	ebid_alu_if.alu bus
);
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] mask;

	// borrow is reported as inverted carry, so subtract adds the complement
	always_comb
	begin
		sum = '0;
		nib = '0;
		mask = 8'h01 << bus.bitSel;
		bus.res = bus.r;
		bus.cout = bus.cin;
		bus.dcout = 1'b0;
		case (bus.op)
			ALU_ADD:
			begin
				sum = {1'b0, bus.a} + {1'b0, bus.r};
				nib = {1'b0, bus.a[3:0]} + {1'b0, bus.r[3:0]};
				bus.res = sum[7:0];
				bus.cout = sum[8];
				bus.dcout = nib[4];
			end
			ALU_SUB:
			begin
				sum = {1'b0, bus.r} + {1'b0, ~bus.a} + 9'h001;
				nib = {1'b0, bus.r[3:0]} + {1'b0, ~bus.a[3:0]} + 5'h01;
				bus.res = sum[7:0];
				bus.cout = sum[8];
				bus.dcout = nib[4];
			end
			ALU_OR:   bus.res = bus.a | bus.r;
			ALU_AND:  bus.res = bus.a & bus.r;
			ALU_XOR:  bus.res = bus.a ^ bus.r;
			ALU_COM:  bus.res = ~bus.r;
			ALU_INC:  bus.res = bus.r + 8'h01;
			ALU_DEC:  bus.res = bus.r - 8'h01;
			ALU_RRC:
			begin
				bus.res = {bus.cin, bus.r[7:1]};
				bus.cout = bus.r[0];
			end
			ALU_RLC:
			begin
				bus.res = {bus.r[6:0], bus.cin};
				bus.cout = bus.r[7];
			end
			ALU_SWAP: bus.res = {bus.r[3:0], bus.r[7:4]};
			ALU_CLR:  bus.res = 8'h00;
			ALU_BCLR: bus.res = bus.r & ~mask;
			ALU_BSET: bus.res = bus.r | mask;
			default:  bus.res = bus.r;
		endcase
		bus.zero = (bus.res == 8'h00);
	end
endmodule
`default_nettype wire

/* File: hw/ebid_alu_if.sv */
// operand and result bundle between the decoder core and its alu
`timescale 1ns/1ps
`default_nettype none
interface ebid_alu_if;
	import ebid_pkg::*;
	logic [7:0]   a;
	logic [7:0]   r;
	logic         cin;
	ebid_alu_op_t op;
	logic [2:0]   bitSel;
	logic [7:0]   res;
	logic         cout;
	logic         dcout;
	logic         zero;
	modport core (output a, r, cin, op, bitSel,
		input res, cout, dcout, zero);
	modport alu (input a, r, cin, op, bitSel,
		output res, cout, dcout, zero);
endinterface
`default_nettype wire

/* File: hw/ebid_core.sv */
// instruction decoder and executor of the eight-bit accumulator core
`timescale 1ns/1ps
`default_nettype none
// Function
// - set, clear, test any register bit
// - i/o data registers behave as general registers
// - 64 registers, bank from bank register bits 7:6
// - literals are 8 or 10 bits wide
// - sleep clears watchdog, stops oscillator, sets timeout flag, clears power-down flag
// - return from interrupt pops, enables interrupts
// - table jump adds accumulator, two cycles
// - rotate right through carry, carry only
// - rotate left through carry, selectable destination
// - nibble swap, no flags
// - decrement, skip on zero, no flags
// - increment, skip on zero, no flags
// - call pushes next address, jumps, two cycles
// - return with literal loads accumulator, pops
// - software interrupt pushes, jumps to one
module ebid_core
	import ebid_pkg::*;
#(
	parameter int STACK_DEPTH = STACK_DEPTH_DEF
)
(
	input  wire logic                 ref_clk,
	input  wire logic                 nrst,
	input  wire logic [INSTR_W-1:0]   progData,
	input  wire logic [7:0]           regRdata,
	input  wire logic                 wakeUp,
	output var  logic [PC_W-1:0]      pcOut,
	output var  logic [BANK_W+REG_IDX_W-1:0] regAddr,
	output var  logic                 regWe,
	output var  logic [7:0]           regWdata,
	output var  logic [7:0]           accOut,
	output var  logic [2:0]           flagsOut,
	output var  logic                 timeoutFlag,
	output var  logic                 powerDownFlag,
	output var  logic                 wdtClear,
	output var  logic                 oscStop,
	output var  logic                 globalIntEn
);
	localparam int SP_W = $clog2(STACK_DEPTH);

	ebid_alu_if aluBus ();
	ebid_alu uAlu (.bus(aluBus));

	ebid_state_t              state, next_state;
	logic [INSTR_W-1:0]       instr, next_instr;
	logic [PC_W-1:0]          pc, next_pc;
	logic [PC_W-1:0]          stack [STACK_DEPTH];
	logic [PC_W-1:0]          next_stack [STACK_DEPTH];
	logic [SP_W-1:0]          sp, next_sp;
	logic [7:0]               acc, next_acc;
	logic                     zFlag, next_zFlag;
	logic                     cFlag, next_cFlag;
	logic                     dcFlag, next_dcFlag;
	logic [PAGE_W-1:0]        page, next_page;
	logic [BANK_W-1:0]        bank, next_bank;
	logic [BANK_W+REG_IDX_W-1:0] next_regAddr;
	logic                     next_regWe;
	logic [7:0]               next_regWdata;
	logic                     next_timeout, next_powerDown;
	logic                     next_wdtClear, next_oscStop, next_intEn;
	logic [2:0]               wakeSync;
	logic                     wakeSeen, next_wakeSeen;

	// decode scratch
	logic [PC_W-1:0]          pcInc;
	logic [8:0]               tblSum;
	logic                     toReg, setZ, setCarry, setAll, bubble;
	logic                     skip, bitSkip, zSkip, push, pop, regBit;
	ebid_alu_op_t             aluOp;
	logic [7:0]               aluR;

	// wake pin crosses in from outside: three stages, act when 2 and 3 agree
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			wakeSync <= 3'h0;
			wakeSeen <= 1'b0;
		end
		else
		begin
			wakeSync <= {wakeSync[1:0], wakeUp};
			wakeSeen <= next_wakeSeen;
		end
	end
	assign next_wakeSeen = (wakeSync[1] == wakeSync[2]) ?
		wakeSync[2] : wakeSeen;

	assign pcInc = pc + 14'h0001;
	assign tblSum = pcInc[8:0] + {1'b0, acc};
	assign regBit = regRdata[instr[8:6]];

	assign aluBus.a = acc;
	assign aluBus.r = aluR;
	assign aluBus.cin = cFlag;
	assign aluBus.op = aluOp;
	assign aluBus.bitSel = instr[8:6];

	// instruction field decode into alu op, destination and flag class
	always_comb
	begin
		aluOp = ALU_PASS;
		aluR = regRdata;
		toReg = 1'b0;
		setZ = 1'b0;
		setCarry = 1'b0;
		setAll = 1'b0;
		bubble = 1'b0;
		bitSkip = 1'b0;
		zSkip = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		if (!instr[12] && !instr[11])
		begin
			toReg = instr[6];
			case (instr[10:8])
				3'h0:
				begin
					if (instr == OP_TABLE)
					begin
						aluOp = ALU_ADD;
						aluR = pcInc[7:0];
						setAll = 1'b1;
						bubble = 1'b1;
						toReg = 1'b0;
					end
					else if (instr[7:6] == 2'b01)
						aluOp = ALU_PASS;
					else if (instr[7:6] == 2'b11)
					begin
						aluOp = ALU_CLR;
						setZ = 1'b1;
					end
					else if (instr == OP_CLR_ACC)
					begin
						aluOp = ALU_CLR;
						setZ = 1'b1;
					end
					else
						toReg = 1'b0;
					if (instr[7:6] == 2'b01)
						aluR = acc;
				end
				3'h1:
				begin
					aluOp = instr[7] ? ALU_DEC : ALU_SUB;
					setAll = !instr[7];
					setZ = instr[7];
				end
				3'h2:
				begin
					aluOp = instr[7] ? ALU_AND : ALU_OR;
					setZ = 1'b1;
				end
				3'h3:
				begin
					aluOp = instr[7] ? ALU_ADD : ALU_XOR;
					setAll = instr[7];
					setZ = !instr[7];
				end
				3'h4:
				begin
					aluOp = instr[7] ? ALU_COM : ALU_PASS;
					setZ = 1'b1;
				end
				3'h5:
				begin
					aluOp = instr[7] ? ALU_DEC : ALU_INC;
					setZ = !instr[7];
					zSkip = instr[7];
				end
				3'h6:
				begin
					aluOp = instr[7] ? ALU_RLC : ALU_RRC;
					setCarry = 1'b1;
				end
				default:
				begin
					aluOp = instr[7] ? ALU_INC : ALU_SWAP;
					zSkip = instr[7];
				end
			endcase
		end
		else if (!instr[12])
		begin
			toReg = !instr[10];
			// a bit test only reads, so the accumulator must not see it
			if (!instr[10])
				aluOp = instr[9] ? ALU_BSET : ALU_BCLR;
			bitSkip = instr[10] && (regBit == instr[9]);
		end
		else if (!instr[11])
		begin
			bubble = 1'b1;
			push = !instr[10];
		end
		else
		begin
			aluR = instr[7:0];
			case (instr[10:8])
				3'h1: aluOp = ALU_OR;
				3'h2: aluOp = ALU_AND;
				3'h3: aluOp = ALU_XOR;
				3'h5: aluOp = ALU_SUB;
				3'h7: aluOp = ALU_ADD;
				default: aluOp = ALU_PASS;
			endcase
			// software interrupt and page select leave the flags alone
			setZ = (instr[10:8] != 3'h0) && (instr[10:8] != 3'h4) &&
				(instr[10:8] != 3'h6);
			setAll = (instr[10:8] == 3'h5) || (instr[10:8] == 3'h7);
			pop = (instr[10:8] == 3'h4);
			bubble = pop;
			push = (instr == OP_SOFT_INT);
		end
		if (instr == OP_RETURN || instr == OP_RET_INT)
		begin
			pop = 1'b1;
			bubble = 1'b1;
		end
	end

	// zero skips are resolved after the alu, outside the decode process,
	// so no combinational loop runs back through it
	assign skip = bitSkip || (zSkip && aluBus.zero);

	// sequencing: read phase, execute phase, optional idle instruction cycle
	always_comb
	begin
		next_state = state;
		next_instr = instr;
		next_pc = pc;
		next_stack = stack;
		next_sp = sp;
		next_acc = acc;
		next_zFlag = zFlag;
		next_cFlag = cFlag;
		next_dcFlag = dcFlag;
		next_page = page;
		next_bank = bank;
		next_regAddr = regAddr;
		next_regWe = 1'b0;
		next_regWdata = regWdata;
		next_timeout = timeoutFlag;
		next_powerDown = powerDownFlag;
		next_wdtClear = 1'b0;
		next_oscStop = oscStop;
		next_intEn = globalIntEn;
		case (state)
			ST_READ:
			begin
				next_instr = progData;
				next_regAddr = {bank, progData[5:0]};
				next_state = ST_EXEC;
			end
			ST_EXEC:
			begin
				next_state = (bubble || skip) ? ST_IDLE_A : ST_READ;
				next_pc = skip ? pc + 14'h0002 : pcInc;
				if (toReg)
				begin
					next_regWe = 1'b1;
					next_regWdata = aluBus.res;
					if (regAddr[REG_IDX_W-1:0] == BANK_REG_IDX)
						next_bank = aluBus.res[BANK_LSB+BANK_W-1:BANK_LSB];
				end
				else if (aluOp != ALU_PASS || instr[12:8] == 5'h04 ||
					(instr[12:11] == 2'b11 && instr[10:8] != 3'h6))
					next_acc = aluBus.res;
				if (setZ || setAll)
					next_zFlag = aluBus.zero;
				if (setAll || setCarry)
					next_cFlag = aluBus.cout;
				if (setAll)
					next_dcFlag = aluBus.dcout;
				if (instr == OP_TABLE)
				begin
					next_acc = acc;
					next_pc = {pcInc[PC_W-1:9], tblSum};
				end
				if (push)
				begin
					next_stack[sp] = pcInc;
					next_sp = sp + SP_W'(1);
				end
				if (pop)
				begin
					next_sp = sp - SP_W'(1);
					next_pc = stack[sp - SP_W'(1)];
				end
				if (instr[12:11] == 2'b10)
					next_pc = {page, instr[LIT_LONG_W-1:0]};
				if (instr == OP_SOFT_INT)
					next_pc = SOFT_INT_VECTOR;
				if (instr[12:4] == 9'h1E8)
					next_page = instr[3:0];
				if (instr == OP_INT_EN || instr == OP_RET_INT)
					next_intEn = 1'b1;
				if (instr == OP_INT_DIS)
					next_intEn = 1'b0;
				if (instr == OP_WDT_CLEAR)
				begin
					next_wdtClear = 1'b1;
					next_timeout = 1'b1;
					next_powerDown = 1'b1;
				end
				if (instr == OP_SLEEP)
				begin
					next_wdtClear = 1'b1;
					next_oscStop = 1'b1;
					next_timeout = 1'b1;
					next_powerDown = 1'b0;
					next_state = ST_SLEEP;
				end
			end
			ST_IDLE_A: next_state = ST_IDLE_B;
			ST_IDLE_B: next_state = ST_READ;
			default:
			begin
				// only the filtered wake level may restart the core
				if (wakeSeen)
				begin
					next_oscStop = 1'b0;
					next_state = ST_READ;
				end
			end
		endcase
	end

	// state registers; stack contents need no reset, pointer does
	always_ff @(posedge ref_clk)
	begin
		stack <= next_stack;
		if (!nrst)
		begin
			state <= ST_READ;
			instr <= '0;
			pc <= PC_RESET;
			sp <= '0;
			acc <= ACC_RESET;
			zFlag <= 1'b0;
			cFlag <= 1'b0;
			dcFlag <= 1'b0;
			page <= PAGE_RESET;
			bank <= BANK_RESET;
			regAddr <= '0;
			regWe <= 1'b0;
			regWdata <= 8'h00;
			timeoutFlag <= TIMEOUT_RESET;
			powerDownFlag <= POWERDOWN_RESET;
			wdtClear <= 1'b0;
			oscStop <= 1'b0;
			globalIntEn <= 1'b0;
		end
		else
		begin
			state <= next_state;
			instr <= next_instr;
			pc <= next_pc;
			sp <= next_sp;
			acc <= next_acc;
			zFlag <= next_zFlag;
			cFlag <= next_cFlag;
			dcFlag <= next_dcFlag;
			page <= next_page;
			bank <= next_bank;
			regAddr <= next_regAddr;
			regWe <= next_regWe;
			regWdata <= next_regWdata;
			timeoutFlag <= next_timeout;
			powerDownFlag <= next_powerDown;
			wdtClear <= next_wdtClear;
			oscStop <= next_oscStop;
			globalIntEn <= next_intEn;
		end
	end

	assign pcOut = pc;
	assign accOut = acc;
	assign flagsOut = {zFlag, dcFlag, cFlag};
endmodule
`default_nettype wire

/* File: hw/ebid_pkg.sv */
// constants, opcodes and types for the eight-bit instruction decoder
package ebid_pkg;
	localparam int PC_W       = 14;
	localparam int PAGE_W     = 4;
	localparam int LIT_LONG_W = 10;
	localparam int LIT_SHORT_W = 8;
	localparam int REG_IDX_W  = 6;
	localparam int BANK_W     = 2;
	localparam int BANK_LSB   = 6;
	localparam int INSTR_W    = 13;
	localparam int STACK_DEPTH_DEF = 8;

	localparam logic [5:0]         BANK_REG_IDX = 6'h04;
	localparam logic [INSTR_W-1:0] OP_SLEEP     = 13'h0003;
	localparam logic [INSTR_W-1:0] OP_WDT_CLEAR = 13'h0004;
	localparam logic [INSTR_W-1:0] OP_INT_EN    = 13'h0010;
	localparam logic [INSTR_W-1:0] OP_INT_DIS   = 13'h0011;
	localparam logic [INSTR_W-1:0] OP_RETURN    = 13'h0012;
	localparam logic [INSTR_W-1:0] OP_RET_INT   = 13'h0013;
	localparam logic [INSTR_W-1:0] OP_TABLE     = 13'h0020;
	localparam logic [INSTR_W-1:0] OP_CLR_ACC   = 13'h0080;
	localparam logic [INSTR_W-1:0] OP_SOFT_INT  = 13'h1E01;
	localparam logic [PC_W-1:0]    SOFT_INT_VECTOR = 14'h0001;
	localparam logic [PC_W-1:0]    PC_RESET     = 14'h0000;
	localparam logic [7:0]         ACC_RESET    = 8'h00;
	localparam logic [PAGE_W-1:0]  PAGE_RESET   = 4'h0;
	localparam logic [BANK_W-1:0]  BANK_RESET   = 2'h0;
	localparam logic               TIMEOUT_RESET   = 1'b1;
	localparam logic               POWERDOWN_RESET = 1'b1;

	typedef enum logic [3:0] {
		ALU_PASS, ALU_ADD, ALU_SUB, ALU_OR, ALU_AND, ALU_XOR, ALU_COM,
		ALU_INC, ALU_DEC, ALU_RRC, ALU_RLC, ALU_SWAP, ALU_CLR,
		ALU_BCLR, ALU_BSET
	} ebid_alu_op_t;

	typedef enum logic [2:0] {
		ST_READ, ST_EXEC, ST_IDLE_A, ST_IDLE_B, ST_SLEEP
	} ebid_state_t;
endpackage
